// ==== src/cfn_nav.sv ====
/*
 Card file system navigator: current directory, current file, record
 pointer, selection by identifier, path, short identifier and name.
 Assumes commands from logic on clk_i, one taken per cmd_ready_o.
*/
`timescale 1ns/1ps
`default_nettype none
module cfn_nav
  import cfn_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cmd_valid_i,
  input  wire cfn_op_e           cmd_op_i,
  input  wire logic [15:0]       cmd_fid_i,
  input  wire logic [15:0]       path_fid_i [PMAX],
  input  wire logic [2:0]        path_len_i,
  input  wire logic [4:0]        sfi_i,
  input  wire cfn_rmode_e        rec_mode_i,
  input  wire logic [7:0]        rec_num_i,
  input  wire logic [15:0]       bin_off_i,
  input  wire logic [15:0]       bin_len_i,
  input  wire logic              abort_i,
  input  wire logic [IW-1:0]     app_dir_i,
  input  wire logic [127:0]      aid_i,
  input  wire logic [4:0]        aid_len_i,
  input  wire logic [IW-1:0]     new_parent_i,
  input  wire cfn_ftype_e        new_type_i,
  input  wire cfn_sfi_e          new_sfi_mode_i,
  input  wire logic [4:0]        new_sfi_i,
  input  wire logic [7:0]        new_nrec_i,
  input  wire logic [7:0]        new_rlen_i,
  input  wire logic [15:0]       new_size_i,
  output logic                   cmd_ready_o,
  output logic                   done_o,
  output cfn_status_e            status_o,
  output logic [IW-1:0]          cur_dir_o,
  output logic [IW-1:0]          cur_ef_o,
  output logic                   ef_sel_o,
  output logic [7:0]             rec_ptr_o,
  output logic [7:0]             phys_rec_o,
  output logic [15:0]            byte_addr_o,
  output logic [15:0]            byte_len_o,
  output logic [IW-1:0]          act_app_o,
  output logic                   app_active_o
);
  logic [NF-1:0]  vld_q;
  logic [15:0]    fid_m  [NF];
  logic [IW-1:0]  par_m  [NF];
  cfn_ftype_e     typ_m  [NF];
  cfn_sfi_e       sfm_m  [NF];
  logic [4:0]     sfv_m  [NF];
  logic [7:0]     nrec_m [NF];
  logic [7:0]     rlen_m [NF];
  logic [15:0]    size_m [NF];
  logic [7:0]     head_m [NF];
  logic [127:0]   aid_m  [NF];
  logic [4:0]     alen_m [NF];
  cfn_state_e     st_q;
  logic [IW-1:0]  pcur_q;
  logic [1:0]     pstep_q;
  logic [2:0]     plen_q;
  logic           pmf_q;
  logic [15:0]    pfid_q [PMAX];

  function automatic logic is_dir(input logic [IW-1:0] i);
    return typ_m[i] inside {FT_MF, FT_DF, FT_ADF};
  endfunction

  // Hit flag above the index of a child with this identifier
  function automatic logic [IW:0] find_child(input logic [IW-1:0] p,
                                             input logic [15:0] f);
    logic [IW:0] r;
    r = '0;
    for (int j = 1; j < NF; j++) begin
      if (vld_q[j] && par_m[j] == p && fid_m[j] == f) begin
        r = {1'b1, IW'(j)};
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] sfi_of(input logic [IW-1:0] i);
    logic [4:0] s;
    s = '0;
    case (sfm_m[i])
      SFI_ABSENT: s = fid_m[i][4:0];
      SFI_GIVEN:  s = sfv_m[i];
      default:    s = '0;
    endcase
    if (is_dir(i) || s < SFI_MIN || s > SFI_MAX) begin
      s = '0;
    end
    return s;
  endfunction

  function automatic logic [IW:0] find_sfi(input logic [IW-1:0] p,
                                           input logic [4:0] s);
    logic [IW:0] r;
    r = '0;
    for (int j = 1; j < NF; j++) begin
      if (vld_q[j] && par_m[j] == p && s != 5'h00 &&
          sfi_of(IW'(j)) == s) begin
        r = {1'b1, IW'(j)};
      end
    end
    return r;
  endfunction

  function automatic logic [IW:0] find_aid(input logic [127:0] a,
                                           input logic [4:0] l);
    logic [IW:0] r;
    r = '0;
    for (int j = 1; j < NF; j++) begin
      if (vld_q[j] && typ_m[j] == FT_ADF && alen_m[j] == l &&
          aid_m[j] == a) begin
        r = {1'b1, IW'(j)};
      end
    end
    return r;
  endfunction

  // Ok flag above the logical record number to act on
  function automatic logic [8:0] rec_tgt(input logic [7:0] p,
                                         input cfn_rmode_e m,
                                         input logic [7:0] num,
                                         input logic [7:0] n,
                                         input logic cyc);
    logic [8:0] r;
    r = '0;
    case (m)
      RM_ABS: r = {num >= REC_ONE && num <= n, num};
      RM_NEXT: begin
        if (p == REC_NONE) r = {1'b1, REC_ONE};
        else if (p == n) r = {cyc, REC_ONE};
        else r = {1'b1, p + REC_ONE};
      end
      RM_PREV: begin
        if (p == REC_NONE) r = {1'b1, n};
        else if (p == REC_ONE) r = {cyc, n};
        else r = {1'b1, p - REC_ONE};
      end
      RM_CUR: r = {p != REC_NONE, p};
      default: r = '0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] phys(input logic [7:0] hd,
                                      input logic [7:0] t,
                                      input logic [7:0] n,
                                      input logic cyc);
    logic [8:0] s;
    s = {1'b0, hd} + {1'b0, t} - 9'h001;
    if (!cyc) s = {1'b0, t} - 9'h001;
    else if (s >= {1'b0, n}) s = s - {1'b0, n};
    return s[7:0];
  endfunction

  logic           sel_go, rec_go, head_go, mk_go, app_go, fin;
  logic [IW-1:0]  sel_t, app_t, mk_i, f;
  logic [7:0]     rec_d, phys_d, hd_d;
  logic [15:0]    ba_d, bl_d;
  cfn_status_e    st_d;
  logic [IW:0]    h, hp;
  logic [8:0]     rt;
  logic [15:0]    pf;
  logic           cyc, take;

  assign take = cmd_valid_i && st_q == S_IDLE;
  assign pf   = pfid_q[pstep_q];

  always_comb begin
    sel_go = 1'b0; rec_go = 1'b0; head_go = 1'b0; mk_go = 1'b0;
    app_go = 1'b0; fin = 1'b0; sel_t = '0; app_t = '0; mk_i = '0;
    f = cur_ef_o; rec_d = rec_ptr_o; phys_d = phys_rec_o; hd_d = '0;
    ba_d = byte_addr_o; bl_d = byte_len_o; st_d = ST_OK;
    h = '0; hp = '0; rt = '0; cyc = 1'b0;
    if (st_q == S_PATH) begin
      h = find_child(pcur_q, pf);
      if (pstep_q == 2'b00 && pmf_q && pf == FID_APP) begin
        h = {app_active_o, act_app_o};
      end
      if (pf == FID_CDIR || (pstep_q == 2'b00 && ((pmf_q &&
          pf == FID_MF) || (!pmf_q && pf == FID_APP)))) begin
        h = '0;
      end
      if (!is_dir(pcur_q) || !h[IW] ||
          (typ_m[h[IW-1:0]] == FT_ADF && h[IW-1:0] != act_app_o)) begin
        fin = 1'b1; st_d = ST_NOT_FOUND;
      end else if ({1'b0, pstep_q} + 3'h1 == plen_q) begin
        fin = 1'b1; sel_go = 1'b1; sel_t = h[IW-1:0];
      end
    end else if (take) begin
      fin = 1'b1;
      case (cmd_op_i)
        OP_SEL_FID: begin
          h = find_child(cur_dir_o, cmd_fid_i);
          hp = find_child(par_m[cur_dir_o], cmd_fid_i);
          if (cmd_fid_i == FID_APP) h = {app_active_o, act_app_o};
          else if (cmd_fid_i == FID_MF) h = {1'b1, MF_IDX};
          else if (!h[IW] && cmd_fid_i == fid_m[cur_dir_o])
            h = {1'b1, cur_dir_o};
          else if (!h[IW] && cur_dir_o != MF_IDX &&
                   cmd_fid_i == fid_m[par_m[cur_dir_o]])
            h = {1'b1, par_m[cur_dir_o]};
          else if (!h[IW] && cur_dir_o != MF_IDX && hp[IW] &&
                   is_dir(hp[IW-1:0]))
            h = hp;
          else if (!h[IW] && ef_sel_o && cmd_fid_i == fid_m[cur_ef_o])
            h = {1'b1, cur_ef_o};
          if (h[IW] && typ_m[h[IW-1:0]] == FT_ADF &&
              !(app_active_o && h[IW-1:0] == act_app_o))
            h = '0;
          if (h[IW]) begin
            sel_go = 1'b1; sel_t = h[IW-1:0];
          end else begin
            st_d = ST_NOT_FOUND;
          end
        end
        OP_PATH_MF, OP_PATH_CUR: begin
          fin = 1'b0;
          if (path_len_i == 3'h0 || path_len_i > 3'(PMAX)) begin
            fin = 1'b1; st_d = ST_BAD_PARAM;
          end
        end
        OP_SEL_AID: begin
          h = find_aid(aid_i, aid_len_i);
          if (h[IW]) begin
            sel_go = 1'b1; sel_t = h[IW-1:0];
            app_go = 1'b1; app_t = h[IW-1:0];
          end else begin
            st_d = ST_NOT_FOUND;
          end
        end
        OP_APP_CMD: begin
          if (app_dir_i != cur_dir_o) st_d = ST_CONFLICT;
        end
        OP_CREATE: begin
          h = '0;
          for (int j = NF - 1; j > 0; j--) begin
            if (!vld_q[j]) h = {1'b1, IW'(j)};
          end
          hp = find_child(par_m[new_parent_i], cmd_fid_i);
          mk_i = h[IW-1:0];
          if (!h[IW]) st_d = ST_FULL;
          else if (!vld_q[new_parent_i] || !is_dir(new_parent_i) ||
                   new_type_i == FT_MF)
            st_d = ST_BAD_PARAM;
          else if (find_child(new_parent_i, cmd_fid_i) != '0 ||
                   cmd_fid_i == fid_m[new_parent_i] || hp[IW] ||
                   cmd_fid_i == FID_MF || cmd_fid_i == FID_APP ||
                   cmd_fid_i == FID_CDIR)
            st_d = ST_CONFLICT;
          else if (new_sfi_mode_i == SFI_GIVEN &&
                   (new_sfi_i < SFI_MIN || new_sfi_i > SFI_MAX))
            st_d = ST_BAD_PARAM;
          else if (new_type_i != FT_ADF && !(new_sfi_mode_i == SFI_EMPTY)
                   && find_sfi(new_parent_i, new_sfi_mode_i == SFI_GIVEN ?
                   new_sfi_i : cmd_fid_i[4:0]) != '0)
            st_d = ST_CONFLICT;
          else if (new_type_i == FT_ADF && (aid_len_i < AID_MIN ||
                   aid_len_i > AID_MAX || find_aid(aid_i, aid_len_i) != '0))
            st_d = ST_CONFLICT;
          else if ((new_type_i == FT_LINEAR || new_type_i == FT_CYCLIC)
                   && (new_nrec_i == REC_NONE || new_nrec_i > REC_MAX ||
                   new_rlen_i == 8'h00 || (new_type_i == FT_CYCLIC &&
                   new_rlen_i > RLEN_CYC) || new_rlen_i > RLEN_LIN))
            st_d = ST_BAD_PARAM;
          else mk_go = 1'b1;
        end
        default: begin
          // Binary, record, increase and search share file resolution
          h = {ef_sel_o, cur_ef_o};
          rec_d = rec_ptr_o;
          if (sfi_i != 5'h00) begin
            h = find_sfi(cur_dir_o, sfi_i);
            rec_d = REC_NONE;
          end
          f = h[IW-1:0];
          cyc = typ_m[f] == FT_CYCLIC;
          rt = rec_tgt(rec_d, rec_mode_i, rec_num_i, nrec_m[f], cyc);
          if (!h[IW]) begin
            st_d = ST_NO_EF;
          end else if (abort_i) begin
            st_d = ST_ABORTED;
          end else begin
            sel_go = sfi_i != 5'h00; sel_t = f;
            rec_go = 1'b1;
            if (cmd_op_i == OP_BINARY) begin
              if (typ_m[f] != FT_TRANSP) st_d = ST_WRONG_TYPE;
              else if ({1'b0, bin_off_i} + {1'b0, bin_len_i} >
                       {1'b0, size_m[f]}) st_d = ST_BAD_PARAM;
              else begin
                ba_d = BIN_BASE + bin_off_i;
                bl_d = bin_len_i;
              end
            end else if (cmd_op_i == OP_REC_RD ||
                         cmd_op_i == OP_REC_UPD) begin
              if (!(typ_m[f] == FT_LINEAR || cyc)) begin
                st_d = ST_WRONG_TYPE;
              end else if (cmd_op_i == OP_REC_UPD && cyc) begin
                if (rec_mode_i != RM_PREV) begin
                  st_d = ST_BAD_PARAM;
                end else begin
                  phys_d = phys(head_m[f], nrec_m[f], nrec_m[f], 1'b1);
                  hd_d = phys_d; head_go = 1'b1;
                  rec_d = REC_ONE;
                end
              end else if (!rt[8]) begin
                st_d = ST_NO_RECORD;
              end else begin
                rec_d = rt[7:0];
                phys_d = phys(head_m[f], rt[7:0], nrec_m[f], cyc);
              end
            end
            if (st_d != ST_OK) begin
              sel_go = 1'b0; rec_go = 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      pcur_q <= MF_IDX;
      pstep_q <= 2'b00;
      plen_q <= 3'h0;
      pmf_q <= 1'b0;
      for (int k = 0; k < PMAX; k++) pfid_q[k] <= '0;
    end else if (st_q == S_IDLE) begin
      if (take && (cmd_op_i == OP_PATH_MF || cmd_op_i == OP_PATH_CUR) &&
          !fin) begin
        st_q <= S_PATH;
        pmf_q <= cmd_op_i == OP_PATH_MF;
        pcur_q <= cmd_op_i == OP_PATH_MF ? MF_IDX : cur_dir_o;
        pstep_q <= 2'b00;
        plen_q <= path_len_i;
        pfid_q <= path_fid_i;
      end
    end else if (fin) begin
      st_q <= S_IDLE;
    end else begin
      pcur_q <= h[IW-1:0];
      pstep_q <= pstep_q + 2'b01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_dir_o <= MF_IDX;
      cur_ef_o <= MF_IDX;
      ef_sel_o <= 1'b0;
      act_app_o <= MF_IDX;
      app_active_o <= 1'b0;
    end else begin
      if (sel_go && is_dir(sel_t)) begin
        cur_dir_o <= sel_t;
        ef_sel_o <= 1'b0;
      end else if (sel_go) begin
        cur_dir_o <= par_m[sel_t];
        cur_ef_o <= sel_t;
        ef_sel_o <= 1'b1;
      end
      if (app_go) begin
        act_app_o <= app_t;
        app_active_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rec_ptr_o <= REC_NONE;
      phys_rec_o <= 8'h00;
      byte_addr_o <= BIN_BASE;
      byte_len_o <= 16'h0000;
    end else begin
      if (rec_go) rec_ptr_o <= rec_d;
      else if (sel_go) rec_ptr_o <= REC_NONE;
      if (rec_go) phys_rec_o <= phys_d;
      if (rec_go) byte_addr_o <= ba_d;
      if (rec_go) byte_len_o <= bl_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ready_o <= 1'b1;
      done_o <= 1'b0;
      status_o <= ST_OK;
    end else begin
      cmd_ready_o <= !(st_q == S_IDLE && take && !fin) &&
                     !(st_q == S_PATH && !fin);
      done_o <= fin;
      if (fin) status_o <= st_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vld_q <= {{(NF-1){1'b0}}, 1'b1};
      for (int k = 0; k < NF; k++) begin
        fid_m[k] <= FID_MF;
        par_m[k] <= MF_IDX;
        typ_m[k] <= FT_MF;
        sfm_m[k] <= SFI_EMPTY;
        sfv_m[k] <= 5'h00;
        nrec_m[k] <= REC_NONE;
        rlen_m[k] <= 8'h00;
        size_m[k] <= 16'h0000;
        head_m[k] <= 8'h00;
        aid_m[k] <= '0;
        alen_m[k] <= 5'h00;
      end
    end else begin
      if (mk_go) begin
        vld_q[mk_i] <= 1'b1;
        fid_m[mk_i] <= cmd_fid_i;
        par_m[mk_i] <= new_parent_i;
        typ_m[mk_i] <= new_type_i;
        sfm_m[mk_i] <= new_sfi_mode_i;
        sfv_m[mk_i] <= new_sfi_i;
        nrec_m[mk_i] <= new_nrec_i;
        rlen_m[mk_i] <= new_rlen_i;
        size_m[mk_i] <= new_size_i;
        head_m[mk_i] <= 8'h00;
        aid_m[mk_i] <= aid_i;
        alen_m[mk_i] <= aid_len_i;
      end
      if (head_go) head_m[f] <= hd_d;
    end
  end
endmodule
`default_nettype wire

// ==== src/cfn_pkg.sv ====
/*
 Shared constants and types of the card file navigator.
 Assumes a single synchronous clock domain around the block.
*/
`default_nettype none
package cfn_pkg;
  localparam int unsigned NF       = 16;
  localparam int unsigned IW       = 4;
  localparam int unsigned PMAX     = 4;
  localparam logic [IW-1:0] MF_IDX = 4'h0;
  localparam logic [15:0] FID_MF   = 16'h3F00;
  localparam logic [15:0] FID_APP  = 16'h7FFF;
  localparam logic [15:0] FID_CDIR = 16'h3FFF;
  localparam logic [15:0] BIN_BASE = 16'h0000;
  localparam logic [7:0]  REC_MAX  = 8'hFE;
  localparam logic [7:0]  RLEN_LIN = 8'hFF;
  localparam logic [7:0]  RLEN_CYC = 8'hFE;
  localparam logic [7:0]  REC_NONE = 8'h00;
  localparam logic [7:0]  REC_ONE  = 8'h01;
  localparam logic [4:0]  SFI_MIN  = 5'h01;
  localparam logic [4:0]  SFI_MAX  = 5'h1E;
  localparam logic [4:0]  AID_MIN  = 5'h01;
  localparam logic [4:0]  AID_MAX  = 5'h10;

  typedef enum logic [3:0] {
    OP_SEL_FID  = 4'b0000, OP_PATH_MF  = 4'b0001,
    OP_PATH_CUR = 4'b0010, OP_SEL_AID  = 4'b0011,
    OP_REC_RD   = 4'b0100, OP_REC_UPD  = 4'b0101,
    OP_BINARY   = 4'b0110, OP_CREATE   = 4'b0111,
    OP_INCREASE = 4'b1000, OP_SEARCH   = 4'b1001,
    OP_APP_CMD  = 4'b1010
  } cfn_op_e;

  typedef enum logic [2:0] {
    FT_MF = 3'b000, FT_DF = 3'b001, FT_ADF = 3'b010,
    FT_TRANSP = 3'b011, FT_LINEAR = 3'b100, FT_CYCLIC = 3'b101
  } cfn_ftype_e;

  // File control parameter short identifier object
  typedef enum logic [1:0] {
    SFI_ABSENT = 2'b00, SFI_EMPTY = 2'b01, SFI_GIVEN = 2'b10
  } cfn_sfi_e;

  typedef enum logic [1:0] {
    RM_ABS = 2'b00, RM_NEXT = 2'b01, RM_PREV = 2'b10, RM_CUR = 2'b11
  } cfn_rmode_e;

  typedef enum logic [3:0] {
    ST_OK = 4'b0000, ST_NOT_FOUND = 4'b0001, ST_BAD_PARAM = 4'b0010,
    ST_NO_EF = 4'b0011, ST_WRONG_TYPE = 4'b0100, ST_NO_RECORD = 4'b0101,
    ST_ABORTED = 4'b0110, ST_CONFLICT = 4'b0111, ST_FULL = 4'b1000
  } cfn_status_e;

  typedef enum logic [0:0] {
    S_IDLE = 1'b0, S_PATH = 1'b1
  } cfn_state_e;
endpackage
`default_nettype wire

// ==== testbench/cfn_nav_properties.sv ====
/*
 Checker of the navigator: completion, pointer and selection relations.
 Assumes a bind to cfn_nav; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cfn_nav_properties
  import cfn_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          cmd_valid_i,
  input wire cfn_op_e       cmd_op_i,
  input wire logic [4:0]    sfi_i,
  input wire logic          abort_i,
  input wire logic          cmd_ready_o,
  input wire logic          done_o,
  input wire cfn_status_e   status_o,
  input wire logic [IW-1:0] cur_dir_o,
  input wire logic [IW-1:0] cur_ef_o,
  input wire logic          ef_sel_o,
  input wire logic [7:0]    rec_ptr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cmd_valid_i && cmd_ready_o;
  endsequence
  a_reset_root: assert property (
    $fell(rst_i) |-> cur_dir_o == MF_IDX && !ef_sel_o && rec_ptr_o == 8'h00)
    else $error("state after reset is not the root");
  a_fail_keeps: assert property (
    done_o && status_o != ST_OK |-> $stable(cur_dir_o) && $stable(ef_sel_o)
      && $stable(rec_ptr_o))
    else $error("failed command changed the selection");
  a_ptr_on_done: assert property (!done_o |-> $stable(rec_ptr_o))
    else $error("record pointer moved without completion");
  a_abort_keeps: assert property (
    s_take ##0 (abort_i && cmd_op_i inside {OP_REC_RD, OP_REC_UPD})
      |=> done_o && status_o == ST_ABORTED)
    else $error("aborted record command not refused");
  a_ptr_limit: assert property (rec_ptr_o <= REC_MAX)
    else $error("record pointer beyond limit");
  a_ef_not_root: assert property (ef_sel_o |-> cur_ef_o != MF_IDX)
    else $error("root reported as current file");
  a_sel_clears_ptr: assert property (
    s_take ##0 (cmd_op_i == OP_SEL_FID)
      |=> done_o && (status_o != ST_OK || rec_ptr_o == REC_NONE))
    else $error("selection left a record pointer");
  a_sfi_selects: assert property (
    s_take ##0 (cmd_op_i == OP_REC_RD && sfi_i != 5'h00 && !abort_i)
      |=> done_o && (status_o != ST_OK || ef_sel_o && rec_ptr_o != 8'h00))
    else $error("short identifier read did not select a file");
  a_path_bounded: assert property (
    s_take ##0 (cmd_op_i inside {OP_PATH_MF, OP_PATH_CUR}) |-> ##[1:6] done_o)
    else $error("path walk did not finish");
endmodule
bind cfn_nav cfn_nav_properties chk_u (.clk_i, .rst_i, .cmd_valid_i,
  .cmd_op_i, .sfi_i, .abort_i, .cmd_ready_o, .done_o, .status_o,
  .cur_dir_o, .cur_ef_o, .ef_sel_o, .rec_ptr_o);
`default_nettype wire

// ==== testbench/cfn_term.sv ====
/*
 Terminal model issuing create, select, path and record commands.
 Assumes the navigator takes a request while its ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
module cfn_term
  import cfn_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       cmd_ready_i,
  input  wire logic       done_i,
  output logic            cmd_valid_o,
  output cfn_op_e         cmd_op_o,
  output logic [15:0]     cmd_fid_o,
  output logic [15:0]     path_fid_o [PMAX],
  output logic [2:0]      path_len_o,
  output logic [4:0]      sfi_o,
  output cfn_rmode_e      rec_mode_o,
  output logic [7:0]      rec_num_o,
  output logic            abort_o,
  output logic [IW-1:0]   new_parent_o,
  output cfn_ftype_e      new_type_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = OP_SEL_FID;
    cmd_fid_o = 16'h0000;
    path_fid_o = '{default: 16'h0000};
    path_len_o = 3'h1;
    sfi_o = 5'h00;
    rec_mode_o = RM_ABS;
    rec_num_o = 8'h00;
    abort_o = 1'b0;
    new_parent_o = 4'h0;
    new_type_o = FT_DF;
  end
  // First two path elements and the length are the caller's choice
  task automatic path(input logic [15:0] a, b, input logic [2:0] n);
    @(negedge clk_i);
    path_fid_o[0] = a;
    path_fid_o[1] = b;
    path_len_o = n;
  endtask
  task automatic send(input cfn_op_e op, input logic [15:0] file_identifier,
      input logic [4:0] short_file_ident, input cfn_rmode_e m, input logic [7:0] num,
      input logic ab, input logic [IW-1:0] par, input cfn_ftype_e typ,
      output logic ok);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_fid_o = file_identifier;
    sfi_o = short_file_ident;
    rec_mode_o = m;
    rec_num_o = num;
    abort_o = ab;
    new_parent_o = par;
    new_type_o = typ;
    do @(posedge clk_i); while (cmd_ready_i !== 1'b1);
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_fid_o = ~file_identifier;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      if (done_i === 1'b1) ok = 1'b1;
      else @(negedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_card_file_select_record_nav.sv ====
/*
 Self-checking bench of the file navigator with a terminal model.
 Assumes the checker binds itself to the navigator.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_card_file_select_record_nav
  import cfn_pkg::*;
;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          cmd_valid_i, abort_i, cmd_ready_o, done_o, ef_sel_o;
  logic          app_active_o;
  cfn_op_e       cmd_op_i;
  cfn_rmode_e    rec_mode_i;
  cfn_ftype_e    new_type_i;
  cfn_status_e   status_o;
  logic [15:0]   cmd_fid_i, byte_addr_o, byte_len_o;
  logic [15:0]   path_fid_i [PMAX];
  logic [2:0]    path_len_i;
  logic [4:0]    sfi_i;
  logic [7:0]    rec_num_i, rec_ptr_o, phys_rec_o;
  logic [IW-1:0] new_parent_i, cur_dir_o, cur_ef_o, act_app_o;
  int            n_fail = 0;
  int            n_tests = 0;
  always #50 clk_i = ~clk_i;
  cfn_nav dut_u (.clk_i, .rst_i, .cmd_valid_i, .cmd_op_i, .cmd_fid_i,
    .path_fid_i, .path_len_i, .sfi_i, .rec_mode_i, .rec_num_i, .abort_i,
    .bin_off_i({12'h000, cmd_fid_i[7:4]}),
    .bin_len_i({12'h000, cmd_fid_i[3:0]}), .app_dir_i(new_parent_i),
    .aid_i({112'h0, cmd_fid_i}), .aid_len_i(rec_num_i[4:0]), .new_parent_i,
    .new_type_i,
    .new_sfi_mode_i(SFI_ABSENT), .new_sfi_i(cmd_fid_i[4:0]),
    .new_nrec_i(rec_num_i), .new_rlen_i(rec_num_i),
    .new_size_i({8'h00, rec_num_i}), .cmd_ready_o, .done_o, .status_o,
    .cur_dir_o, .cur_ef_o, .ef_sel_o, .rec_ptr_o, .phys_rec_o,
    .byte_addr_o, .byte_len_o, .act_app_o, .app_active_o);
  cfn_term term_u (.clk_i, .cmd_ready_i(cmd_ready_o), .done_i(done_o),
    .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i), .cmd_fid_o(cmd_fid_i),
    .path_fid_o(path_fid_i), .path_len_o(path_len_i), .sfi_o(sfi_i),
    .rec_mode_o(rec_mode_i), .rec_num_o(rec_num_i), .abort_o(abort_i),
    .new_parent_o(new_parent_i), .new_type_o(new_type_i));
  task automatic chk(input string nm, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input cfn_op_e op, input logic [15:0] file_identifier,
      input logic [4:0] short_file_ident, input cfn_rmode_e m, input logic ab,
      input cfn_status_e st, input logic [IW-1:0] par = 4'h0,
      input cfn_ftype_e typ = FT_DF);
    logic ok;
    term_u.send(op, file_identifier, short_file_ident, m, 8'h03, ab, par, typ, ok);
    chk("done", 16'h0001, {15'h0000, ok});
    chk("status", st, status_o);
  endtask
  task automatic t_select;
    logic ok;
    chk("reset dir", MF_IDX, cur_dir_o);
    chk("reset ef", 16'h0000, ef_sel_o);
    run(OP_CREATE, 16'h7F10, 5'h00, RM_ABS, 0, ST_OK, 4'h0, FT_DF);
    run(OP_CREATE, 16'h6F01, 5'h00, RM_ABS, 0, ST_OK, 4'h1, FT_LINEAR);
    run(OP_CREATE, 16'h6F02, 5'h00, RM_ABS, 0, ST_OK, 4'h1, FT_CYCLIC);
    term_u.send(OP_CREATE, 16'h6F05, 5'h00, RM_ABS, 8'hFF, 1'b0, 4'h1,
      FT_LINEAR, ok);
    chk("too many", ST_BAD_PARAM, status_o);
    run(OP_CREATE, 16'h6F03, 5'h00, RM_ABS, 0, ST_OK, 4'h1,
      FT_TRANSP);
    run(OP_SEL_FID, 16'h7F10, 5'h00, RM_ABS, 0, ST_OK);
    chk("dir", 16'h0001, cur_dir_o);
    chk("ef sel", 16'h0000, ef_sel_o);
    run(OP_SEL_FID, 16'h6F01, 5'h00, RM_ABS, 0, ST_OK);
    chk("ef", 16'h0002, cur_ef_o);
    chk("dir kept", 16'h0001, cur_dir_o);
    run(OP_SEL_FID, 16'h1234, 5'h00, RM_ABS, 0, ST_NOT_FOUND);
    chk("ef kept", 16'h0002, cur_ef_o);
  endtask
  task automatic t_linear;
    run(OP_REC_RD, 16'h0000, 5'h00, RM_PREV, 0, ST_OK);
    chk("ptr last", 16'h0003, rec_ptr_o);
    chk("slot last", 16'h0002, phys_rec_o);
    run(OP_REC_RD, 16'h0000, 5'h00, RM_NEXT, 0, ST_NO_RECORD);
    run(OP_REC_RD, 16'h0000, 5'h00, RM_PREV, 1, ST_ABORTED);
    chk("ptr kept", 16'h0003, rec_ptr_o);
    run(OP_SEL_FID, 16'h6F01, 5'h00, RM_ABS, 0, ST_OK);
    run(OP_REC_RD, 16'h0000, 5'h00, RM_NEXT, 0, ST_OK);
    chk("ptr first", 16'h0001, rec_ptr_o);
    run(OP_REC_RD, 16'h0000, 5'h00, RM_PREV, 0, ST_NO_RECORD);
  endtask
  task automatic t_cyclic;
    logic ok;
    run(OP_REC_RD, 16'h0000, 5'h02, RM_NEXT, 0, ST_OK);
    chk("sfi ef", 16'h0003, cur_ef_o);
    chk("sfi ptr", 16'h0001, rec_ptr_o);
    run(OP_REC_RD, 16'h0000, 5'h00, RM_PREV, 0, ST_OK);
    chk("wrap back", 16'h0003, rec_ptr_o);
    run(OP_REC_RD, 16'h0000, 5'h00, RM_NEXT, 0, ST_OK);
    chk("wrap fwd", 16'h0001, rec_ptr_o);
    term_u.send(OP_REC_UPD, 16'h0000, 5'h00, RM_NEXT, 8'h01, 1'b0, 4'h0,
      FT_DF, ok);
    chk("upd refused", 16'h0001, {15'h0000, status_o != ST_OK});
    run(OP_REC_UPD, 16'h0000, 5'h00, RM_PREV, 0, ST_OK);
    chk("newest", 16'h0001, rec_ptr_o);
    chk("oldest slot", 16'h0002, phys_rec_o);
    run(OP_BINARY, 16'h0013, 5'h03, RM_ABS, 0, ST_BAD_PARAM);
    run(OP_BINARY, 16'h0012, 5'h03, RM_ABS, 0, ST_OK);
    chk("bin ef", 16'h0004, cur_ef_o);
    chk("byte addr", 16'h0001, byte_addr_o);
    chk("byte len", 16'h0002, byte_len_o);
  endtask
  task automatic t_path;
    term_u.path(16'h7F10, 16'h6F01, 3'h2);
    run(OP_SEL_FID, 16'h3F00, 5'h00, RM_ABS, 0, ST_OK);
    chk("root", MF_IDX, cur_dir_o);
    run(OP_PATH_MF, 16'h0000, 5'h00, RM_ABS, 0, ST_OK);
    chk("path ef", 16'h0002, cur_ef_o);
    term_u.path(16'h3F00, 16'h7F10, 3'h2);
    run(OP_PATH_MF, 16'h0000, 5'h00, RM_ABS, 0, ST_NOT_FOUND);
    term_u.path(16'h3FFF, 16'h6F02, 3'h2);
    run(OP_PATH_CUR, 16'h0000, 5'h00, RM_ABS, 0, ST_NOT_FOUND);
    term_u.path(16'h6F02, 16'h0000, 3'h0);
    run(OP_PATH_CUR, 16'h0000, 5'h00, RM_ABS, 0, ST_BAD_PARAM);
    chk("path kept", 16'h0002, cur_ef_o);
    run(OP_CREATE, 16'h7F20, 5'h00, RM_ABS, 0, ST_OK, 4'h0,
      FT_ADF);
    run(OP_SEL_AID, 16'h7F20, 5'h00, RM_ABS, 0, ST_OK);
    chk("app", 16'h0005, act_app_o);
    chk("app on", 16'h0001, app_active_o);
    run(OP_APP_CMD, 16'h0000, 5'h00, RM_ABS, 0, ST_CONFLICT,
      4'h1);
    run(OP_APP_CMD, 16'h0000, 5'h00, RM_ABS, 0, ST_OK, 4'h5);
    run(OP_SEL_FID, 16'h3F00, 5'h00, RM_ABS, 0, ST_OK);
    run(OP_SEL_FID, 16'h7FFF, 5'h00, RM_ABS, 0, ST_OK);
    chk("app dir", 16'h0005, cur_dir_o);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    t_select();
    t_linear();
    t_cyclic();
    t_path();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
